// >>> pkg/rrag_pkg.sv
// Constants and types for the RAM/ROM address generation block
// Summary of operation
// - Register indirect mode forms a 10-bit RAM address from the three pointer registers.
// - Direct RAM mode takes two words, the opcode first and the 10-bit address second.
// - A memory register area of 16 four-bit digits in RAM serves the load and swap instructions.
// - Long jump, alternate long jump and long call load all 14 program counter bits.
// - ROM is 32 pages of 256 words and a page jump replaces the low eight bits, keeping the page unless it sits on the last word.
// - A page jump on the last word of a page lands in the following page.
// - A zero-page call puts six immediate bits in bits 5 to 0 and clears bits 13 to 6.
// - A table jump target comes from the two top PC bits, four immediate bits, the accumulator and the second register.
// - A table read with ROM bit 8 set writes its eight data bits to accumulator and second register.
// - A table read with ROM bit 9 set writes its eight data bits to the two port output registers.
// - With both bits set a table read updates both destinations in the same operation.
// - A table read leaves the program counter to normal sequencing.
package rrag_pkg;
  localparam int PC_W = 14;
  localparam int RAM_AW = 10;
  localparam int PAGE_LO_W = 8;
  localparam int ZP_W = 6;
  localparam int PAGE_COUNT = 32;
  localparam int PAGE_WORDS = 256;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [PAGE_LO_W-1:0] PAGE_LAST = 8'hFF;
  localparam logic [RAM_AW-1:0] MEMREG_BASE = 10'h040;
  localparam int MEMREG_DIGITS = 16;
  localparam int ROM_TR_BIT = 8;
  localparam int ROM_PORT_BIT = 9;
  localparam logic [2:0] W_RESET = 3'h0;
  localparam logic [3:0] NIB_RESET = 4'h0;

  typedef enum logic [2:0] {
    RRAG_RAM_INDIRECT = 3'b001,
    RRAG_RAM_DIRECT = 3'b010,
    RRAG_RAM_MEMREG = 3'b100
  } rrag_ram_mode_t;

  typedef enum logic [6:0] {
    RRAG_PC_SEQ = 7'b0000001,
    RRAG_PC_LONG_JUMP = 7'b0000010,
    RRAG_PC_ALT_LONG_JUMP = 7'b0000100,
    RRAG_PC_LONG_CALL = 7'b0001000,
    RRAG_PC_PAGE_JUMP = 7'b0010000,
    RRAG_PC_ZERO_CALL = 7'b0100000,
    RRAG_PC_TABLE_JUMP = 7'b1000000
  } rrag_pc_op_t;

  typedef enum logic [1:0] {
    RRAG_ST_FETCH = 2'b01,
    RRAG_ST_SECOND = 2'b10
  } rrag_state_t;
endpackage

// >>> verilog/rrag_ram_addr.sv
// RAM address former for the three data addressing modes
`timescale 1ns/1ps
module rrag_ram_addr #(
  parameter int AW = 10
) (
  input wire logic [2:0] mode,
  input wire logic [2:0] ptr_w,
  input wire logic [3:0] ptr_x,
  input wire logic [3:0] ptr_y,
  input wire logic [AW-1:0] direct_addr,
  input wire logic [3:0] memreg_index,
  output logic [AW-1:0] ram_addr
);
  always_comb begin
    case (mode)
      rrag_pkg::RRAG_RAM_INDIRECT: ram_addr = {ptr_w, ptr_x, ptr_y[2:0]};
      rrag_pkg::RRAG_RAM_DIRECT: ram_addr = direct_addr;
      rrag_pkg::RRAG_RAM_MEMREG: ram_addr = rrag_pkg::MEMREG_BASE | {6'h00, memreg_index};
      default: ram_addr = {ptr_w, ptr_x, ptr_y[2:0]};
    endcase
  end
endmodule

// >>> verilog/rrag_core.sv
// Program counter, table read and RAM address generation top
`timescale 1ns/1ps
module rrag_core (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic word_valid,
  input wire logic [9:0] word,
  input wire logic [6:0] pc_op,
  input wire logic two_word,
  input wire logic [2:0] ram_mode,
  input wire logic [2:0] ptr_w,
  input wire logic [3:0] ptr_x,
  input wire logic [3:0] ptr_y,
  input wire logic [3:0] memreg_index,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] breg_in,
  input wire logic table_read,
  input wire logic [9:0] rom_data,
  output logic [13:0] pc,
  output logic [13:0] table_addr,
  output logic [9:0] ram_addr,
  output logic ram_addr_valid,
  output logic acc_we,
  output logic [3:0] acc_out,
  output logic [3:0] breg_out,
  output logic [3:0] port1_out,
  output logic [3:0] port2_out
);
  ////////////////////////////////////////////////////////////////////////
  // All state in one record, so a field added here is reset in one place below
  typedef struct packed {
    rrag_pkg::rrag_state_t st;
    logic [6:0] held_op;
    logic [2:0] held_mode;
    logic [13:0] pc;
    logic [13:0] op_pc;
    logic [9:0] direct_addr;
    logic ram_valid;
    logic acc_we;
    logic [3:0] acc;
    logic [3:0] breg;
    logic [3:0] p1;
    logic [3:0] p2;
  } rrag_core_state_t;

  rrag_core_state_t r;
  rrag_core_state_t next_r;
  logic [13:0] tbl;
  logic [13:0] seq_pc;
  logic [13:0] page_next;
  logic [13:0] zero_next;
  logic [13:0] long_next;

  // Two PC bits on top, then immediate, then accumulator, then second register
  function automatic logic [13:0] rrag_table_target(input logic [13:0] base,
      input logic [3:0] imm, input logic [3:0] a, input logic [3:0] b);
    rrag_table_target = {base[13:12], imm, a, b};
  endfunction

  // In-page target; the jump's own PC picks the page, so the last word wraps on
  function automatic logic [13:0] rrag_page_target(input logic [13:0] at,
      input logic [7:0] imm);
    logic [5:0] page;
    page = at[13:8];
    if (at[7:0] == rrag_pkg::PAGE_LAST) begin
      page = page + 6'h01;
    end
    rrag_page_target = {page, imm};
  endfunction

  // Zero-page call: six immediate bits, upper eight bits cleared
  function automatic logic [13:0] rrag_zero_target(input logic [5:0] imm);
    rrag_zero_target = {8'h00, imm};
  endfunction

  // Long forms: low nibble of the first word on top of the ten bits of the second
  function automatic logic [13:0] rrag_long_target(input logic [3:0] hi,
      input logic [9:0] lo);
    rrag_long_target = {hi, lo};
  endfunction

  // True for the three ops that reload the whole PC from a second word
  function automatic logic rrag_is_long(input logic [6:0] op);
    case (op)
      rrag_pkg::RRAG_PC_LONG_JUMP,
      rrag_pkg::RRAG_PC_ALT_LONG_JUMP,
      rrag_pkg::RRAG_PC_LONG_CALL: begin
        rrag_is_long = 1'b1;
      end
      default: begin
        rrag_is_long = 1'b0;
      end
    endcase
  endfunction

  // Table-read destination flags sit in the two top bits of the ROM word
  function automatic logic rrag_rom_flag(input logic [9:0] data, input int pos);
    rrag_rom_flag = data[pos];
  endfunction

  // Candidate targets, worked out every cycle and picked by the next-state logic
  assign tbl = rrag_table_target(r.pc, word[3:0], acc_in, breg_in);
  assign seq_pc = r.pc + 14'h0001;
  assign page_next = rrag_page_target(r.pc, word[7:0]);
  assign zero_next = rrag_zero_target(word[5:0]);
  assign long_next = rrag_long_target(r.direct_addr[3:0], word);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic; pulses are cleared first so they last one cycle
  always_comb begin
    next_r = r;
    next_r.acc_we = 1'b0;
    next_r.ram_valid = 1'b0;
    if (word_valid) begin
      next_r.pc = seq_pc;
      case (r.st)
        rrag_pkg::RRAG_ST_FETCH: begin
          next_r.op_pc = r.pc;
          if (two_word) begin
            // Long forms step the PC by one and wait for the second word to load the target
            next_r.st = rrag_pkg::RRAG_ST_SECOND;
            next_r.held_op = pc_op;
            next_r.held_mode = ram_mode;
            next_r.direct_addr = {r.direct_addr[9:4], word[3:0]};
          end else begin
            next_r.ram_valid = 1'b1;
            next_r.held_mode = ram_mode;
            case (pc_op)
              rrag_pkg::RRAG_PC_PAGE_JUMP: begin
                next_r.pc = page_next;
              end
              rrag_pkg::RRAG_PC_ZERO_CALL: begin
                next_r.pc = zero_next;
              end
              rrag_pkg::RRAG_PC_TABLE_JUMP: begin
                next_r.pc = tbl;
              end
              default: begin
                next_r.pc = seq_pc;
              end
            endcase
          end
        end
        rrag_pkg::RRAG_ST_SECOND: begin
          // Second words carry no opcode; only the held one counts
          next_r.st = rrag_pkg::RRAG_ST_FETCH;
          next_r.direct_addr = word;
          next_r.ram_valid = 1'b1;
          if (rrag_is_long(r.held_op)) begin
            next_r.pc = long_next;
          end else begin
            next_r.pc = seq_pc;
          end
        end
        default: begin
          next_r.st = rrag_pkg::RRAG_ST_FETCH;
        end
      endcase
    end
    // Table read touches only data destinations, never the PC
    if (table_read) begin
      if (rrag_rom_flag(rom_data, rrag_pkg::ROM_TR_BIT)) begin
        next_r.acc = rom_data[3:0];
        next_r.breg = rom_data[7:4];
        next_r.acc_we = 1'b1;
      end
      if (rrag_rom_flag(rom_data, rrag_pkg::ROM_PORT_BIT)) begin
        next_r.p1 = rom_data[3:0];
        next_r.p2 = rom_data[7:4];
      end
    end
  end

  // Synchronous reset loads every field, so no output is unknown after release
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r.st <= rrag_pkg::RRAG_ST_FETCH;
      r.held_op <= rrag_pkg::RRAG_PC_SEQ;
      r.held_mode <= rrag_pkg::RRAG_RAM_INDIRECT;
      r.pc <= rrag_pkg::PC_RESET;
      r.op_pc <= rrag_pkg::PC_RESET;
      r.direct_addr <= 10'h000;
      r.ram_valid <= 1'b0;
      r.acc_we <= 1'b0;
      r.acc <= rrag_pkg::NIB_RESET;
      r.breg <= rrag_pkg::NIB_RESET;
      r.p1 <= rrag_pkg::NIB_RESET;
      r.p2 <= rrag_pkg::NIB_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Combinational from the held mode and the live pointers, so a pointer
  // update reaches RAM without an extra cycle
  rrag_ram_addr #(
    .AW(rrag_pkg::RAM_AW)
  ) u_ram_addr (
    .mode(r.held_mode),
    .ptr_w(ptr_w),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .direct_addr(r.direct_addr),
    .memreg_index(memreg_index),
    .ram_addr(ram_addr)
  );

  // Both address buses are combinational; everything else leaves a flop
  assign pc = r.pc;
  assign table_addr = tbl;
  assign ram_addr_valid = r.ram_valid;
  assign acc_we = r.acc_we;
  assign acc_out = r.acc;
  assign breg_out = r.breg;
  assign port1_out = r.p1;
  assign port2_out = r.p2;
endmodule

// >>> bench/rrag_core_props.sv
// Concurrent checks on the address generation core ports
`timescale 1ns/1ps
module rrag_core_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic word_valid,
  input wire logic [9:0] word,
  input wire logic [6:0] pc_op,
  input wire logic two_word,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] breg_in,
  input wire logic table_read,
  input wire logic [9:0] rom_data,
  input wire logic [13:0] pc,
  input wire logic [13:0] table_addr,
  input wire logic acc_we,
  input wire logic [3:0] acc_out,
  input wire logic [3:0] breg_out,
  input wire logic [3:0] port1_out,
  input wire logic [3:0] port2_out
);
  // Tracks second words, since the opcode is only valid on the first one
  logic sec;
  logic [3:0] hi_q;
  logic [6:0] op_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) sec <= 1'b0;
    else if (word_valid) sec <= !sec && two_word;
    if (word_valid && !sec) hi_q <= word[3:0];
    if (word_valid && !sec) op_q <= pc_op;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  step_a: assert property (word_valid && !(!sec && |pc_op[6:4]) && !(sec && |op_q[3:1])
    |=> pc == $past(pc) + 14'h0001) else $error("pc did not step");
  long_a: assert property (word_valid && sec && |op_q[3:1]
    |=> pc == {$past(hi_q), $past(word)}) else $error("long target wrong");
  page_a: assert property (word_valid && !sec && pc_op[4]
    |=> pc[7:0] == $past(word[7:0])) else $error("page jump low byte wrong");
  wrap_a: assert property (word_valid && !sec && pc_op[4]
    |=> pc[13:8] == $past(pc[13:8]) + ($past(pc[7:0]) == 8'hFF)) else $error("page wrong");
  zero_a: assert property (word_valid && !sec && pc_op[5]
    |=> pc == {8'h00, $past(word[5:0])}) else $error("zero call wrong");
  tjump_a: assert property (word_valid && !sec && pc_op[6]
    |=> pc == $past(table_addr)) else $error("table jump wrong");
  taddr_a: assert property (table_addr == {pc[13:12], word[3:0], acc_in, breg_in})
    else $error("table address wrong");
  acc_a: assert property (table_read && rom_data[8]
    |=> acc_we && {breg_out, acc_out} == $past(rom_data[7:0])) else $error("acc not loaded");
  port_a: assert property (table_read && rom_data[9]
    |=> {port2_out, port1_out} == $past(rom_data[7:0])) else $error("ports not loaded");
  hold_a: assert property (table_read && !word_valid |=> $stable(pc))
    else $error("table read moved pc");
endmodule
bind rrag_core rrag_core_props chk_u (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .word_valid(word_valid),
  .word(word),
  .pc_op(pc_op),
  .two_word(two_word),
  .acc_in(acc_in),
  .breg_in(breg_in),
  .table_read(table_read),
  .rom_data(rom_data),
  .pc(pc),
  .table_addr(table_addr),
  .acc_we(acc_we),
  .acc_out(acc_out),
  .breg_out(breg_out),
  .port1_out(port1_out),
  .port2_out(port2_out)
);

// >>> bench/rrag_rom_model.sv
// Program ROM model answering table addresses
`timescale 1ns/1ps
module rrag_rom_model (
  input wire logic [13:0] table_addr,
  output logic [9:0] rom_data
);
  // Contents follow the address so every read is predictable; flag bits come from low bits
  assign rom_data = {table_addr[1:0], table_addr[11:4]};
endmodule

// >>> bench/rrag_core_tb.sv
// Self-checking bench for the address generation core
`timescale 1ns/1ps
module rrag_core_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, word_valid = 1'b0, two_word = 1'b0, table_read = 1'b0;
  logic [9:0] word = 10'h000, rom_data, ram_addr;
  logic [6:0] pc_op = 7'h01;
  logic [2:0] ram_mode = 3'h1, ptr_w = 3'h0;
  logic [3:0] ptr_x = 4'h0, ptr_y = 4'h0, memreg_index = 4'h0, acc_in = 4'h0, breg_in = 4'h0;
  logic [13:0] pc, table_addr, tj;
  logic ram_addr_valid, acc_we;
  logic [3:0] acc_out, breg_out, port1_out, port2_out;
  logic [7:0] exp_ab = 8'h00, exp_pt = 8'h00;
  logic [31:0] r, lw;
  integer seed = 32'hEA43, mismatches = 0, tests_run = 0, i;
  rrag_core dut_u (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .word_valid(word_valid),
    .word(word),
    .pc_op(pc_op),
    .two_word(two_word),
    .ram_mode(ram_mode),
    .ptr_w(ptr_w),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .memreg_index(memreg_index),
    .acc_in(acc_in),
    .breg_in(breg_in),
    .table_read(table_read),
    .rom_data(rom_data),
    .pc(pc),
    .table_addr(table_addr),
    .ram_addr(ram_addr),
    .ram_addr_valid(ram_addr_valid),
    .acc_we(acc_we),
    .acc_out(acc_out),
    .breg_out(breg_out),
    .port1_out(port1_out),
    .port2_out(port2_out)
  );
  rrag_rom_model rom_u (.table_addr(table_addr), .rom_data(rom_data));
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [13:0] got, input logic [13:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One call is one cycle, driven just after the edge
  task st(input logic v, input logic [9:0] w, input logic [6:0] op, input logic tw,
    input logic [2:0] m, input logic tr);
    @(posedge sys_clk);
    #1;
    word_valid = v;
    word = w;
    pc_op = op;
    two_word = tw;
    ram_mode = m;
    table_read = tr;
  endtask
  // Expected page jump target from the address of the jump itself
  function automatic logic [13:0] page_tgt(input logic [13:0] at, input logic [7:0] imm);
    logic [5:0] pg;
    pg = at[13:8];
    if (at[7:0] == 8'hFF) pg = pg + 6'h01;
    page_tgt = {pg, imm};
  endfunction
  task finish_test;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    chk(pc, 14'h0000);
    for (i = 0; i < 3; i++) begin
      lw = $random(seed);
      st(1, {6'h00, lw[13:10]}, 7'h02 << i, 1, 3'h1, 0);
      st(1, {lw[9:8], 8'hFF}, 7'h01, 0, 3'h1, 0);
      st(1, {2'h0, lw[21:14]}, 7'h10, 0, 3'h1, 0);
      chk(pc, {lw[13:8], 8'hFF});
      st(0, 10'h000, 7'h01, 0, 3'h1, 0);
      tj = page_tgt({lw[13:8], 8'hFF}, lw[21:14]);
      chk(pc, tj);
      st(1, {3'h0, lw[28:22]}, 7'h10, 0, 3'h1, 0);
      st(0, 10'h000, 7'h01, 0, 3'h1, 0);
      chk(pc, page_tgt(tj, {1'b0, lw[28:22]}));
    end
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      acc_in = r[3:0];
      breg_in = {r[7:6], i[1:0]};
      {ptr_w, ptr_x, ptr_y, memreg_index} = r[22:8];
      st(1, r[31:22], 7'h20, 0, 3'h4, 0);
      st(0, r[31:22], 7'h01, 0, 3'h1, 1);
      chk(pc, {8'h00, r[27:22]});
      chk({4'h0, ram_addr}, {4'h0, 10'h040 | {6'h00, memreg_index}});
      if (i[0]) exp_ab = {r[25:22], r[3:0]};
      if (i[1]) exp_pt = {r[25:22], r[3:0]};
      st(1, r[31:22], 7'h40, 0, 3'h1, 0);
      chk(pc, {8'h00, r[27:22]});
      chk({6'h00, breg_out, acc_out}, {6'h00, exp_ab});
      chk({6'h00, port2_out, port1_out}, {6'h00, exp_pt});
      chk({13'h0000, acc_we}, {13'h0000, i[0]});
      tj = {2'h0, r[25:22], acc_in, breg_in};
      st(1, r[31:22], 7'h01, 1, 3'h2, 0);
      chk(pc, tj);
      chk({4'h0, ram_addr}, {4'h0, ptr_w, ptr_x, ptr_y[2:0]});
      st(1, r[21:12], 7'h01, 0, 3'h2, 0);
      st(0, 10'h000, 7'h01, 0, 3'h1, 0);
      chk(pc, tj + 14'h0002);
      chk({4'h0, ram_addr}, {4'h0, r[21:12]});
      chk({13'h0000, ram_addr_valid}, 14'h0001);
    end
    // Mid-run reset: all back to idle, and the first word may follow at once
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    chk(pc, 14'h0000);
    chk({6'h00, port2_out, port1_out}, 14'h0000);
    chk({6'h00, breg_out, acc_out}, 14'h0000);
    st(1, 10'h000, 7'h01, 0, 3'h1, 0);
    st(0, 10'h000, 7'h01, 0, 3'h1, 0);
    chk(pc, 14'h0001);
    finish_test;
  end
  // Bounds the whole run so a stalled sequence still reaches a verdict
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
